// ==== include/feacrx_defs.vh ====
// Constants for the receive code block: offsets, fields, resets, counts.
// Assumes a 12-bit host address whose top nibble selects the port.
`ifndef FEACRX_DEFS_VH
`define FEACRX_DEFS_VH
`define FRX_OFF_CTRL 8'hd0
`define FRX_OFF_LIVE 8'hd4
`define FRX_OFF_LATCH 8'hd6
`define FRX_OFF_IEN 8'hd8
`define FRX_OFF_FDATA 8'hdc
`define FRX_BIT_SRST 0
`define FRX_BIT_IDLE 0
`define FRX_BIT_CWD 1
`define FRX_BIT_OVF 2
`define FRX_BIT_EMPTY 3
`define FRX_BIT_INVAL 7
`define FRX_CTRL_RST 16'h0800
`define FRX_LATCH_RST 3'h1
`define FRX_IEN_RST 3'h0
`define FRX_CODE_W 6
`define FRX_FIFO_DEPTH 32
`define FRX_FIFO_AW 5
`define FRX_CW_LEN 5'h10
`define FRX_IDLE_LEN 5'h10
`define FRX_VALID_CNT 3'h3
`endif

// ==== verilog/feacrx_fifo.v ====
// First-in first-out store for received codes, show-ahead output.
// Assumes push and pop come from logic on the same clock.
`default_nettype none
module feacrx_fifo #(
    parameter W = 6,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire mclk, // System clock.
    input wire reset, // Asynchronous reset, active high.
    input wire clr, // Synchronous flush.
    input wire in_valid, // Code offered.
    output wire in_ready, // Room for a code.
    input wire [W-1:0] in_data, // Code to store.
    output wire out_valid, // A code is presented.
    input wire out_ready, // Consumer takes the code.
    output wire [W-1:0] out_data // Oldest code.
);
    reg [W-1:0] mem [0:DEPTH-1]; // Code storage.
    reg [AW-1:0] wr_ptr_r; // Write position.
    reg [AW-1:0] rd_ptr_r; // Read position.
    reg [AW:0] count_r; // Number of stored codes.
    wire push; // Accepted write.
    wire pop; // Accepted read.

    // Full and empty come straight from the count.
    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage array is written without reset.
    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and count; a flush empties the store at once.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else if (clr) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/feacrx_latch.v ====
// Sticky event flags: set on a rising live level or an event pulse,
// cleared by writing one. Assumes all inputs are on mclk.
`include "feacrx_defs.vh"
`default_nettype none
module feacrx_latch #(
    parameter N = 3
) (
    input wire mclk, // System clock.
    input wire reset, // Asynchronous reset, active high.
    input wire srst, // Soft reset held by software.
    input wire [N-1:0] rise_in, // Levels whose rising edge sets.
    input wire [N-1:0] clr_in, // Write-one-to-clear strobes.
    input wire [N-1:0] rst_val, // Value taken under soft reset.
    output reg [N-1:0] flag_r // Sticky flags.
);
    reg [N-1:0] prev_r; // Last sampled level.
    // Hard reset values, sized to the flag vector so each bit is a constant.
    localparam [N-1:0] HARD_RST = `FRX_LATCH_RST;
    genvar i;

    generate
        for (i = 0; i < N; i = i + 1) begin : g_flag
            // Set wins over a clear in the same cycle.
            always @(posedge mclk or posedge reset) begin
                if (reset) begin
                    prev_r[i] <= 1'b0;
                    flag_r[i] <= HARD_RST[i];
                end else if (srst) begin
                    prev_r[i] <= 1'b0;
                    flag_r[i] <= rst_val[i];
                end else begin
                    prev_r[i] <= rise_in[i];
                    if (rise_in[i] & ~prev_r[i]) begin
                        flag_r[i] <= 1'b1;
                    end else if (clr_in[i]) begin
                        flag_r[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== verilog/feacrx_top.v ====
// Per-port receive code unit: finds codewords and idle in the bit
// stream, queues codes, keeps live and sticky status, raises requests.
// Assumes the host bus and framer strobes are synchronous to mclk.
//
// Contract
// - Soft reset holds receiver, empties FIFO, drops data
// - Clearing soft reset resumes normal operation
// - Empty status bit 3 mirrors FIFO empty
// - Live codeword bit set while codeword received
// - Live idle bit 0 set on all-ones
// - Overflow sets latched bit 2, code lost
// - Codeword latched flag sets on rising live
// - Idle latched flag sets on rising live
// - Idle latched flag reads one after reset
// - Overflow request needs flag, enable, port enable
// - Codeword request needs flag, enable, port enable
// - Idle request needs flag, enable; enables reset zero; code also gates it by port enable
// - Data-invalid bit 7 set when FIFO empty
// - Code presented in data bits 5 to 0
// - First received bit lands in bit 0
// - Lower-byte read of data advances FIFO
// - Register set repeats per port at 0,2,4,6
`include "feacrx_defs.vh"
`default_nettype none
module feacrx_top #(
    parameter [1:0] PORT_IDX = 2'h0
) (
    input wire mclk, // System clock, 200 MHz.
    input wire reset, // Asynchronous reset, active high.
    input wire code_bit, // Received code channel bit.
    input wire code_bit_en, // Strobe: code_bit is new this cycle.
    input wire port_global_irq_enable, // This port's global enable.
    input wire host_cs, // Host access select.
    input wire host_rd, // Read strobe, one cycle.
    input wire host_wr, // Write strobe, one cycle.
    input wire [11:0] host_addr, // Byte address, port in top nibble.
    input wire [1:0] host_be, // Byte lanes: bit 0 lower, bit 1 upper.
    input wire [15:0] host_wdata, // Write data.
    output reg [15:0] host_rdata_r, // Read data, one cycle after read.
    output reg irq_req_r // Interrupt request, level.
);
    // Detector and register state.
    reg srst_r; // Soft reset control bit.
    reg [2:0] ien_r; // Interrupt enables.
    reg [15:0] shift_r; // Last sixteen received bits.
    reg [15:0] shift_nxt; // Shift register after this bit.
    reg [4:0] phase_r; // Bits since last codeword match.
    reg [4:0] ones_r; // Consecutive ones, saturating.
    reg [2:0] rep_r; // Matching codewords in a row.
    reg [5:0] last_r; // Code of the last matching codeword.
    reg cwd_live_r; // Codeword currently being received.
    reg idle_live_r; // All-ones idle currently received.
    wire [5:0] code_now; // Code field of the shift register.
    wire cw_match; // Shift register holds a codeword.
    wire push; // Validated code offered to the FIFO.
    wire fifo_ready; // FIFO has room.
    wire fifo_valid; // FIFO holds a code.
    wire [5:0] fifo_code; // Oldest queued code.
    wire fifo_pop; // Host takes the oldest code.
    wire ovf_evt; // A validated code found no room.
    wire [2:0] latch_q; // Sticky flags.
    wire [2:0] latch_clr; // Write-one clear strobes.
    wire [2:0] latch_rise; // Levels driving the sticky flags.
    wire wr_lo; // Write with lower lane enabled.
    wire rd_lo; // Read with lower lane enabled.
    reg ovf_lvl_r; // Overflow event held as a one-cycle level.

    // Address hit for one register of this port.
    // Port address replication
    function hit;
        input [11:0] a;
        input [7:0] off;
        begin
            hit = (a[11:8] == {1'b0, PORT_IDX, 1'b0}) && (a[7:0] == off);
        end
    endfunction

    // Lane qualified strobes.
    assign wr_lo = host_cs & host_wr & host_be[0];
    assign rd_lo = host_cs & host_rd & host_be[0];

    // Next shift value; newest bit enters at the bottom.
    always @* begin
        shift_nxt = {shift_r[14:0], code_bit};
    end

    // Codeword pattern match
    // The first bit of the frame sits at the top of the register.
    assign cw_match = (shift_nxt[15] == 1'b0) && (shift_nxt[8] == 1'b0)
                      && (shift_nxt[7:0] == 8'hff);

    // First bit to field bit 0
    assign code_now = {shift_nxt[9], shift_nxt[10], shift_nxt[11],
                       shift_nxt[12], shift_nxt[13], shift_nxt[14]};

    // Bit stream processing: alignment, repetition count and live
    // status. Soft reset discards everything received.
    // Receiver held in reset
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            shift_r <= 16'h0000;
            phase_r <= 5'h00;
            ones_r <= 5'h00;
            rep_r <= 3'h0;
            last_r <= 6'h00;
            cwd_live_r <= 1'b0;
            idle_live_r <= 1'b0;
        end else if (srst_r) begin
            shift_r <= 16'h0000;
            phase_r <= 5'h00;
            ones_r <= 5'h00;
            rep_r <= 3'h0;
            last_r <= 6'h00;
            cwd_live_r <= 1'b0;
            idle_live_r <= 1'b0;
        end else if (code_bit_en) begin
            shift_r <= shift_nxt;
            if (!code_bit) begin
                ones_r <= 5'h00;
                idle_live_r <= 1'b0;
            end else if (ones_r != `FRX_IDLE_LEN) begin
                ones_r <= ones_r + 5'h01;
                idle_live_r <= (ones_r + 5'h01) == `FRX_IDLE_LEN;
            end
            if (cw_match) begin
                phase_r <= 5'h00;
                last_r <= code_now;
                // A repeat must follow exactly one codeword later.
                if ((phase_r == `FRX_CW_LEN - 5'h01) &&
                    (code_now == last_r)) begin
                    if (rep_r != `FRX_VALID_CNT) begin
                        rep_r <= rep_r + 3'h1;
                    end
                end else begin
                    rep_r <= 3'h1;
                end
                if (push) begin
                    cwd_live_r <= 1'b1;
                end
            end else if (phase_r != `FRX_CW_LEN) begin
                phase_r <= phase_r + 5'h01;
            end else begin
                // Pattern still missing one bit after it was due: codeword ended.
                rep_r <= 3'h0;
                cwd_live_r <= 1'b0;
            end
        end
    end

    // A code is queued once, when its repetition count first validates.
    // Queue validated code
    assign push = code_bit_en & ~srst_r & cw_match &
                  (phase_r == `FRX_CW_LEN - 5'h01) &
                  (code_now == last_r) &
                  (rep_r == `FRX_VALID_CNT - 3'h1);

    assign ovf_evt = push & ~fifo_ready;

    assign fifo_pop = rd_lo & hit(host_addr, `FRX_OFF_FDATA);

    // Code queue; soft reset flushes it.
    // FIFO emptied
    feacrx_fifo #(
        .W(`FRX_CODE_W),
        .DEPTH(`FRX_FIFO_DEPTH),
        .AW(`FRX_FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .clr(srst_r),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(code_now),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_code)
    );

    // Overflow is a pulse; the latch block sees it as a rising level
    // that falls again, so each overflow sets the flag.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            ovf_lvl_r <= 1'b0;
        end else begin
            ovf_lvl_r <= ovf_evt;
        end
    end

    // Write-one clear of sticky flags, lower lane only.
    // Write one clears
    assign latch_clr = (wr_lo && hit(host_addr, `FRX_OFF_LATCH)) ?
                       host_wdata[2:0] : 3'h0;

    assign latch_rise = {ovf_lvl_r, cwd_live_r, idle_live_r};

    feacrx_latch #(
        .N(3)
    ) u_latch (
        .mclk(mclk),
        .reset(reset),
        .srst(srst_r),
        .rise_in(latch_rise),
        .clr_in(latch_clr),
        .rst_val(`FRX_LATCH_RST),
        .flag_r(latch_q)
    );

    // Control and enable registers; lower lane carries every field.
    // Soft reset released
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            srst_r <= 1'b0;
            ien_r <= `FRX_IEN_RST;
        end else if (wr_lo) begin
            if (hit(host_addr, `FRX_OFF_CTRL)) begin
                srst_r <= host_wdata[`FRX_BIT_SRST];
            end else if (hit(host_addr, `FRX_OFF_IEN)) begin
                ien_r <= host_wdata[2:0];
            end
        end
    end

    // Interrupt request: any enabled sticky flag, gated by the port.
    // Gated request
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_req_r <= 1'b0;
        end else begin
            irq_req_r <= port_global_irq_enable & (|(latch_q & ien_r));
        end
    end

    // Read data, registered; unmapped addresses read zero.
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            host_rdata_r <= 16'h0000;
        end else if (host_cs & host_rd) begin
            if (hit(host_addr, `FRX_OFF_CTRL)) begin
                host_rdata_r <= `FRX_CTRL_RST | {15'h0000, srst_r};
            end else if (hit(host_addr, `FRX_OFF_LIVE)) begin
                host_rdata_r <= {12'h000, ~fifo_valid, 1'b0,
                                 cwd_live_r, idle_live_r};
            end else if (hit(host_addr, `FRX_OFF_LATCH)) begin
                host_rdata_r <= {13'h0000, latch_q};
            end else if (hit(host_addr, `FRX_OFF_IEN)) begin
                host_rdata_r <= {13'h0000, ien_r};
            end else if (hit(host_addr, `FRX_OFF_FDATA)) begin
                host_rdata_r <= {8'h00, ~fifo_valid, 1'b0,
                                 fifo_valid ? fifo_code : 6'h00};
            end else begin
                host_rdata_r <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/feacrx_far_end.sv ====
// Far-end line model: sends codewords and idle ones on the code bit.
// Assumes the bench calls its tasks and mclk is the block's clock.
`default_nettype none
module feacrx_far_end (
    input wire logic mclk, // Block clock.
    output logic code_bit, // Line bit to the block.
    output logic code_bit_en // High one cycle per new bit.
);
    timeunit 1ns;
    timeprecision 1ps;
    // The line starts quiet.
    initial begin
        code_bit = 1'b0;
        code_bit_en = 1'b0;
    end
    // Between bits the level means nothing, so it toggles every cycle.
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge mclk);
            code_bit_en = 1'b0;
            code_bit = ~code_bit;
        end
    endtask
    // Gap cycles before a bit make the sender prompt or slow.
    task automatic send_bit(input logic b, input int gap);
        quiet(gap);
        @(negedge mclk);
        code_bit = b;
        code_bit_en = 1'b1;
    endtask
    task automatic send_word(input logic [15:0] w, input int gap);
        for (int i = 0; i < 16; i++) begin
            send_bit(w[i], gap);
        end
        quiet(1);
    endtask
endmodule
`default_nettype wire

// ==== tb/feacrx_checker.sv ====
// Port checker for the receive code unit, bound into its top module.
// Assumes the host bus and the code strobe are on mclk.
`include "feacrx_defs.vh"
`default_nettype none
module feacrx_checker #(
    parameter logic [1:0] PORT_IDX = 2'h0
) (
    input wire logic mclk, // Clock.
    input wire logic reset, // Asynchronous reset.
    input wire logic code_bit, // Line bit.
    input wire logic code_bit_en, // Line bit strobe.
    input wire logic port_global_irq_enable, // Port enable.
    input wire logic host_cs, // Select.
    input wire logic host_rd, // Read strobe.
    input wire logic host_wr, // Write strobe.
    input wire logic [11:0] host_addr, // Address.
    input wire logic [15:0] host_rdata_r, // Read data.
    input wire logic irq_req_r // Request.
);
    logic [4:0] ones_r; // Run of ones seen, saturating.
    wire logic rd_w = host_cs && host_rd; // A read is taken.
    wire logic mine_w = host_addr[11:8] == {1'b0, PORT_IDX, 1'b0};
    wire logic [7:0] o_w = host_addr[7:0]; // Offset.
    wire logic map_w = o_w == `FRX_OFF_CTRL || o_w == `FRX_OFF_LIVE ||
        o_w == `FRX_OFF_LATCH || o_w == `FRX_OFF_IEN || o_w == `FRX_OFF_FDATA;
    // Counts ones; any control write restarts it, as a soft reset restarts the detector.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) ones_r <= 5'h0;
        else if (host_cs && host_wr && mine_w && o_w == `FRX_OFF_CTRL)
            ones_r <= 5'h0;
        else if (code_bit_en)
            ones_r <= !code_bit ? 5'h0 : ones_r + {4'h0, ones_r != 5'h1f};
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    chk_irq_gate: assert property (
        !port_global_irq_enable |=> !irq_req_r)
        else $error("request with port enable low");
    chk_irq_cause: assert property (
        $rose(irq_req_r) |-> $past(port_global_irq_enable))
        else $error("request rose without port enable");
    chk_rdata_hold: assert property (
        !rd_w [*2] |=> $stable(host_rdata_r))
        else $error("read data moved without a read");
    chk_upper_zero: assert property (
        host_rdata_r[15:12] == 4'h0 && host_rdata_r[10:8] == 3'h0)
        else $error("upper read bits not zero");
    chk_fdata_form: assert property (
        rd_w && mine_w && o_w == `FRX_OFF_FDATA ##1 !rd_w |=>
        (host_rdata_r[7] ? host_rdata_r[6:0] == 7'h0 : !host_rdata_r[6]))
        else $error("data register form wrong");
    chk_foreign_zero: assert property (
        rd_w && !(mine_w && map_w) ##1 !rd_w |=> host_rdata_r == 16'h0)
        else $error("foreign read not zero");
    chk_ctrl_fixed: assert property (
        rd_w && mine_w && o_w == `FRX_OFF_CTRL ##1 !rd_w |=>
        host_rdata_r[15:1] == 15'h0400)
        else $error("control read wrong");
    chk_idle_live: assert property (
        rd_w && mine_w && o_w == `FRX_OFF_LIVE && ones_r > 5'h10 &&
        !code_bit_en ##1 !rd_w && !code_bit_en |=> host_rdata_r[0])
        else $error("idle live not set");
    cover property (rd_w && mine_w && o_w == `FRX_OFF_FDATA);
    cover property ($rose(irq_req_r));
    cover property (ones_r == 5'h1f);
endmodule
bind feacrx_top feacrx_checker #(.PORT_IDX(PORT_IDX)) u_chk (.mclk(mclk),
    .reset(reset), .code_bit(code_bit), .code_bit_en(code_bit_en),
    .port_global_irq_enable(port_global_irq_enable), .host_cs(host_cs),
    .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
    .host_rdata_r(host_rdata_r), .irq_req_r(irq_req_r));
`default_nettype wire

// ==== tb/feacrx_tb_top.sv ====
// Self-checking bench for the receive code unit on port 1.
// Assumes the far-end model and the bound checker are compiled first.
`include "feacrx_defs.vh"
`default_nettype none
module feacrx_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] PN = 4'h2; // Address nibble of port 1.
    logic mclk, reset, glb, cs, rd, wr, irq, cb, cbe;
    logic [11:0] addr; // Host address.
    logic [1:0] be; // Byte lanes.
    logic [15:0] wdata, rdata; // Host data.
    logic [31:0] seed = 32'h3477b342; // Random state.
    logic [5:0] c; // Current code.
    int n_errors = 0;
    int total_checks = 0;
    feacrx_far_end far (.mclk(mclk), .code_bit(cb), .code_bit_en(cbe));
    feacrx_top #(.PORT_IDX(2'h1)) dut (.mclk(mclk), .reset(reset),
        .code_bit(cb), .code_bit_en(cbe), .port_global_irq_enable(glb),
        .host_cs(cs), .host_rd(rd), .host_wr(wr), .host_addr(addr),
        .host_be(be), .host_wdata(wdata), .host_rdata_r(rdata),
        .irq_req_r(irq));
    // Xorshift source of repeatable random values.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] cw(input logic [5:0] k);
        return {8'hff, 1'b0, k, 1'b0};
    endfunction
    // Prints the verdict and stops.
    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One host cycle; read data is settled two falling edges later.
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [1:0] b, input logic [15:0] d);
        @(negedge mclk);
        {cs, rd, wr, addr, be, wdata} = {1'b1, !w, w, a, b, d};
        @(negedge mclk);
        {cs, rd, wr} = 3'h0;
        @(negedge mclk);
    endtask
    task automatic put(input logic [7:0] o, input logic [15:0] d);
        acc(1'b1, {PN, o}, 2'b11, d);
    endtask
    task automatic rdc(input string n, input logic [7:0] o, e);
        acc(1'b0, {PN, o}, 2'b01, 16'h0);
        // The control register always reads its fixed upper bit as well.
        check(n, rdata, (o == `FRX_OFF_CTRL ? `FRX_CTRL_RST : 16'h0000)
            | {8'h0, e});
    endtask
    task automatic code3(input logic [5:0] k, input int gap);
        repeat (3) far.send_word(cw(k), gap);
    endtask
    task automatic ones(input int n);
        repeat (n) far.send_bit(1'b1, int'(rnd() % 3));
        far.quiet(1);
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Cuts a hang short.
    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        wrap_up();
    end
    // Main sequence.
    initial begin
        {reset, glb, cs, rd, wr, addr, be, wdata} = {1'b1, 34'h0};
        repeat (2) @(posedge mclk);
        @(negedge mclk) reset = 1'b0;
        rdc("ctrl", `FRX_OFF_CTRL, 8'h00);
        rdc("latch", `FRX_OFF_LATCH, 8'h01);
        rdc("ien", `FRX_OFF_IEN, 8'h00);
        rdc("live", `FRX_OFF_LIVE, 8'h08);
        rdc("data", `FRX_OFF_FDATA, 8'h80);
        rdc("unused", 8'hd2, 8'h00);
        acc(1'b0, {4'h0, `FRX_OFF_LIVE}, 2'b01, 16'h0);
        check("other port", rdata, 16'h0);
        put(`FRX_OFF_LATCH, 16'h7);
        ones(20);
        rdc("live", `FRX_OFF_LIVE, 8'h09);
        rdc("latch", `FRX_OFF_LATCH, 8'h01);
        put(`FRX_OFF_LATCH, 16'h1);
        rdc("latch", `FRX_OFF_LATCH, 8'h00);
        far.send_bit(1'b0, 0);
        far.quiet(1);
        rdc("live", `FRX_OFF_LIVE, 8'h08);
        c = 6'(rnd());
        for (int i = 0; i < 4; i++) begin
            c = c + 6'h1 + 6'(rnd() % 63);
            put(`FRX_OFF_LATCH, 16'h7);
            code3(c, int'(rnd() % 3));
            rdc("live", `FRX_OFF_LIVE, 8'h02);
            rdc("latch", `FRX_OFF_LATCH, 8'h02);
            rdc("code", `FRX_OFF_FDATA, {2'b00, c});
            rdc("data", `FRX_OFF_FDATA, 8'h80);
            ones(20);
            rdc("live", `FRX_OFF_LIVE, 8'h09);
            rdc("latch", `FRX_OFF_LATCH, 8'h03);
        end
        put(`FRX_OFF_LATCH, 16'h7);
        for (int i = 0; i < 33; i++) code3(6'(i), 0);
        rdc("latch", `FRX_OFF_LATCH, 8'h06);
        for (int e = 0; e < 16; e++) begin
            glb = e[0];
            put(`FRX_OFF_IEN, 16'(e >> 1));
            rdc("ien", `FRX_OFF_IEN, 8'(e >> 1));
            check("irq", {15'h0, irq}, {15'h0, e[0] && (e & 12) != 0});
        end
        for (int i = 0; i < 32; i++)
            rdc("queued", `FRX_OFF_FDATA, 8'(i));
        rdc("data", `FRX_OFF_FDATA, 8'h80);
        code3(6'h15, 1);
        put(`FRX_OFF_CTRL, 16'h1);
        rdc("ctrl", `FRX_OFF_CTRL, 8'h01);
        rdc("data", `FRX_OFF_FDATA, 8'h80);
        code3(6'h2a, 0);
        rdc("live", `FRX_OFF_LIVE, 8'h08);
        put(`FRX_OFF_CTRL, 16'h0);
        rdc("latch", `FRX_OFF_LATCH, 8'h01);
        put(`FRX_OFF_IEN, 16'h1);
        check("irq", {15'h0, irq}, 16'h1);
        code3(6'h2a, 0);
        rdc("code", `FRX_OFF_FDATA, 8'h2a);
        wrap_up();
    end
endmodule
`default_nettype wire
